// File: src/invocation_control.sv
// Invocation control of a pipelined component: start/stall in, busy/done out,
// slave-register and always-running variants, shared master port for stores.
// Assumes one clock, a reset released synchronously, and same-clock partners.
`timescale 1ns/1ns
`include "inv_ctrl_regs.svh"
module invocation_control
    import inv_ctrl_pkg::*;
#(
    parameter inv_mode_t MODE        = MODE_HANDSHAKE,
    parameter int        ARG_W       = 32,
    parameter int        ADDR_W      = 32,
    parameter int        LATENCY     = `INV_LATENCY,
    parameter int        INIT_CYCLES = `INV_INIT_CYCLES,
    parameter bit        HAS_GLOBAL  = 1'b1
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              start,
    output logic                   busy,
    input  wire logic              stall,
    output logic                   done,
    output logic [ARG_W-1:0]       returndata,
    input  wire logic [ARG_W-1:0]  arg_in,
    input  wire logic [ARG_W-1:0]  stable_arg,
    input  wire logic              slv_start_wr,
    input  wire logic              slv_done_clr,
    output logic                   slv_done,
    output logic [ARG_W-1:0]       slv_returndata,
    input  wire logic [ADDR_W-1:0] ptr_addr,
    input  wire logic [ADDR_W-1:0] glob_addr,
    output logic [ADDR_W-1:0]      mm_address,
    output logic                   mm_write,
    output logic [ARG_W-1:0]       mm_writedata,
    input  wire logic              mm_waitrequest
);
    localparam int LAST = LATENCY - 1;

    // Elaboration checks
    if (LATENCY < 2) begin : g_bad_lat
        $error("LATENCY must be at least 2");
    end
    if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << `INV_INIT_CNT_W)) begin : g_bad_init
        $error("INIT_CYCLES out of range");
    end

    function automatic logic is_mode(input inv_mode_t m);
        return MODE == m;
    endfunction : is_mode

    init_state_t             st_r, st_nxt;
    logic [`INV_INIT_CNT_W-1:0] icnt_r, icnt_nxt;
    logic                    val_r [LATENCY];
    logic                    val_nxt [LATENCY];
    logic [ARG_W-1:0]        dat_r [LATENCY];
    logic [ARG_W-1:0]        dat_nxt [LATENCY];
    logic [1:0]              pend_r, pend_nxt;
    logic                    sreq_r, sreq_nxt;
    logic                    sdone_r, sdone_nxt;
    logic [ARG_W-1:0]        sret_r, sret_nxt;
    logic                    start_eff, stall_eff, accept, adv, leave, enter;
    logic                    buf_in_ready, buf_out_valid, buf_out_ready;
    logic [ARG_W-1:0]        buf_out_data;

    // Variant-dependent start and stall
    always_comb begin
        start_eff = start;
        stall_eff = stall;
        if (is_mode(MODE_SLAVE_REG)) begin
            start_eff = sreq_r;
        end
        if (is_mode(MODE_ALWAYS_RUN)) begin
            start_eff = 1'b1;
        end
        if (is_mode(MODE_STALL_FREE)) begin
            stall_eff = 1'b0;
        end
    end

    // Pipeline flow control
    assign leave  = val_r[LAST] && (pend_r == 2'b00) && buf_in_ready;
    assign adv    = (st_r == ST_RUN) && (!val_r[LAST] || leave);
    assign busy   = !adv;
    assign accept = start_eff && adv;
    assign enter  = adv && val_r[LAST-1];

    // Start-up sequencing
    always_comb begin
        st_nxt   = st_r;
        icnt_nxt = icnt_r;
        unique case (st_r)
            ST_INIT: begin
                icnt_nxt = icnt_r + 1'b1;
                if (icnt_r == INIT_CYCLES[`INV_INIT_CNT_W-1:0] - 1'b1) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                icnt_nxt = icnt_r;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r   <= ST_INIT;
            icnt_r <= '0;
        end else begin
            st_r   <= st_nxt;
            icnt_r <= icnt_nxt;
        end
    end

    // Pipeline: unstable argument captured at accept, stable one read live
    always_comb begin
        val_nxt = val_r;
        dat_nxt = dat_r;
        if (adv) begin
            val_nxt[0] = accept;
            dat_nxt[0] = arg_in;
            for (int i = 1; i < LATENCY; i++) begin
                val_nxt[i] = val_r[i-1];
                dat_nxt[i] = dat_r[i-1];
            end
            dat_nxt[LAST] = dat_r[LAST-1] + stable_arg;
        end
    end

    always_ff @(posedge clk) begin
        dat_r <= dat_nxt;
        if (!rst_n) begin
            for (int i = 0; i < LATENCY; i++) begin
                val_r[i] <= 1'b0;
            end
        end else begin
            val_r <= val_nxt;
        end
    end

    // Shared master port: pointer store first, then global store
    always_comb begin
        pend_nxt = pend_r;
        if (enter) begin
            pend_nxt[`INV_PEND_PTR]  = 1'b1;
            pend_nxt[`INV_PEND_GLOB] = HAS_GLOBAL;
        end else if (!mm_waitrequest) begin
            if (pend_r[`INV_PEND_PTR]) begin
                pend_nxt[`INV_PEND_PTR] = 1'b0;
            end else begin
                pend_nxt[`INV_PEND_GLOB] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_r <= 2'b00;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    assign mm_write     = |pend_r;
    assign mm_writedata = dat_r[LAST];
    assign mm_address   = pend_r[`INV_PEND_PTR] ? ptr_addr : glob_addr;

    // Completion buffer absorbs receiver stalls
    skid_buffer #(
        .W (ARG_W)
    ) u_done_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (leave),
        .in_ready  (buf_in_ready),
        .in_data   (dat_r[LAST]),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    // Drain policy per variant
    always_comb begin
        buf_out_ready = !stall_eff;
        if (is_mode(MODE_SLAVE_REG)) begin
            buf_out_ready = !sdone_r || slv_done_clr;
        end
        if (is_mode(MODE_ALWAYS_RUN)) begin
            buf_out_ready = 1'b1;
        end
    end

    assign done       = (is_mode(MODE_HANDSHAKE) || is_mode(MODE_STALL_FREE)) && buf_out_valid;
    assign returndata = buf_out_data;

    // Slave registers: start request, done flag, return value
    always_comb begin
        sreq_nxt  = (sreq_r && !accept) || slv_start_wr;
        sdone_nxt = sdone_r && !slv_done_clr;
        sret_nxt  = sret_r;
        if (buf_out_valid && buf_out_ready) begin
            sdone_nxt = 1'b1;                          // set wins over clear
            sret_nxt  = buf_out_data;
        end
        if (!is_mode(MODE_SLAVE_REG)) begin
            sreq_nxt  = 1'b0;
            sdone_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sreq_r  <= 1'b0;
            sdone_r <= `INV_DONE_RST;
            sret_r  <= '0;
        end else begin
            sreq_r  <= sreq_nxt;
            sdone_r <= sdone_nxt;
            sret_r  <= sret_nxt;
        end
    end

    assign slv_done       = sdone_r;
    assign slv_returndata = sret_r;
endmodule : invocation_control

// File: src/inv_ctrl_regs.svh
// Timing counts and reset values for the invocation control block.
// Assumes inclusion by bare name from design files.
// Functional notes
// - Default variant uses start, busy, stall and done handshake.
// - Slave variant keeps start, done and return value in registers.
// - Always-running variant forces start high and has no done output.
// - Stall-free variant has no stall input; stall is held at zero.
// - Unstable arguments are sampled with their own start.
// - Unstable arguments may change between in-flight invocations.
// - Stable applies to scalars, address conduits and slave registers only.
// - Stable pointer makes only the address stable; master port unchanged.
// - Globals and pointers share one master port with arbitration.
// - Constant globals get no master path and no address conduit; HAS_GLOBAL of 0 drops the global store, but the glob_addr input stays.
// - During reset busy is high and done is low.
// - After reset busy stays high until initialization completes.
// - No interface is valid until busy first falls after reset.
`ifndef INV_CTRL_REGS_SVH
`define INV_CTRL_REGS_SVH
`define INV_INIT_CYCLES  16
`define INV_LATENCY      3
`define INV_INIT_CNT_W   8
`define INV_BUSY_RST     1'b1
`define INV_DONE_RST     1'b0
`define INV_PEND_PTR     0
`define INV_PEND_GLOB    1
`endif

// File: src/inv_ctrl_pkg.sv
// Types shared by the invocation control block.
// Assumes nothing beyond a SystemVerilog compiler.
package inv_ctrl_pkg;
    // Invocation variants
    typedef enum logic [1:0] {
        MODE_HANDSHAKE,
        MODE_SLAVE_REG,
        MODE_ALWAYS_RUN,
        MODE_STALL_FREE
    } inv_mode_t;
    // Start-up sequencing
    typedef enum logic {
        ST_INIT,
        ST_RUN
    } init_state_t;
endpackage : inv_ctrl_pkg

// File: src/skid_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module skid_buffer #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic         wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0]   cnt_r, cnt_nxt;
    logic         push, pop;

    // Handshakes and read data
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next pointers, count and storage
    always_comb begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r ^ push;
        rp_nxt  = rp_r ^ pop;
        cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
        if (push) begin
            mem_nxt[wp_r] = in_data;
        end
    end

    // Register stage
    always_ff @(posedge clk) begin
        mem_r <= mem_nxt;
        if (!rst_n) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule : skid_buffer

// File: dv/inv_ctrl_chk.sv
// Checker for handshake, store port and reset outputs of invocation_control.
// Assumes INIT_CYCLES of 3 and ptr_addr different from glob_addr.
`timescale 1ns/1ns
module inv_ctrl_chk #(
    parameter int ARG_W  = 32,
    parameter int ADDR_W = 32
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              start,
    input wire logic              busy,
    input wire logic              stall,
    input wire logic              done,
    input wire logic [ARG_W-1:0]  returndata,
    input wire logic [ADDR_W-1:0] ptr_addr,
    input wire logic [ADDR_W-1:0] glob_addr,
    input wire logic [ADDR_W-1:0] mm_address,
    input wire logic              mm_write,
    input wire logic [ARG_W-1:0]  mm_writedata,
    input wire logic              mm_waitrequest
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Store steps
    sequence s_ptr_done;
        mm_write && !mm_waitrequest && mm_address == ptr_addr;
    endsequence
    sequence s_glob_store;
        mm_write && mm_address == glob_addr;
    endsequence
    // Properties
    property p_rst_out;
        disable iff (1'b0) !rst_n ##1 !rst_n |-> busy && !done && !mm_write;
    endproperty
    property p_init;
        $rose(rst_n) |-> busy[*3] ##[1:8] !busy;
    endproperty
    property p_quiet;
        $rose(rst_n) |-> (!done && !mm_write)[*3];
    endproperty
    property p_answer;
        start && !busy |-> ##[3:60] done;
    endproperty
    property p_stall;
        done && stall |=> done && $stable(returndata);
    endproperty
    property p_hold;
        mm_write && mm_waitrequest |=> mm_write && $stable(mm_address) && $stable(mm_writedata);
    endproperty
    property p_order;
        s_ptr_done |=> s_glob_store ##0 $stable(mm_writedata);
    endproperty
    property p_first;
        $rose(mm_write) |-> mm_address == ptr_addr;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs wrong in reset");
    a_init: assert property (p_init) else $error("busy wrong after reset");
    a_quiet: assert property (p_quiet) else $error("activity before ready");
    a_answer: assert property (p_answer) else $error("no done after accept");
    a_stall: assert property (p_stall) else $error("done moved under stall");
    a_hold: assert property (p_hold) else $error("store moved while waiting");
    a_order: assert property (p_order) else $error("global store missing");
    a_first: assert property (p_first) else $error("store not pointer first");
endmodule : inv_ctrl_chk
bind invocation_control inv_ctrl_chk #(.ARG_W(ARG_W), .ADDR_W(ADDR_W)) u_inv_ctrl_chk (
    .clk(clk), .rst_n(rst_n), .start(start), .busy(busy), .stall(stall), .done(done),
    .returndata(returndata), .ptr_addr(ptr_addr), .glob_addr(glob_addr), .mm_address(mm_address),
    .mm_write(mm_write), .mm_writedata(mm_writedata), .mm_waitrequest(mm_waitrequest));

// File: dv/mem_model.sv
// Memory slave on the store port; logs every accepted write.
// Assumes the same clock as the block and 32-bit address and data.
`timescale 1ns/1ns
module mem_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic [31:0] mm_address,
    input  wire logic        mm_write,
    input  wire logic [31:0] mm_writedata,
    output logic             mm_waitrequest
);
    logic [31:0] wa[$];
    logic [31:0] wd[$];
    logic        tog = 1'b0;
    // Wait every other cycle when slow
    assign mm_waitrequest = slow & tog;
    // Log stores taken
    always @(posedge clk) begin
        tog <= ~tog;
        if (rst_n && mm_write && !mm_waitrequest) begin
            wa.push_back(mm_address);
            wd.push_back(mm_writedata);
        end
    end
endmodule : mem_model

// File: dv/tb.sv
// Testbench for invocation_control in handshake and slave-register modes.
// Assumes mem_model as store target and the bound checker.
`timescale 1ns/1ns
module tb;
    logic        clk = 0, rst_n = 0, start = 0, stall = 0, slow = 0;
    logic [31:0] arg_in = 0, stable_arg = 32'h0000_0100;
    logic [31:0] ptr_addr = 32'h0000_1000, glob_addr = 32'h0000_2000;
    logic        busy, done, mm_write, mm_waitrequest;
    logic [31:0] returndata, mm_address, mm_writedata;
    logic        slv_start_wr = 0, slv_done_clr = 0;
    logic        s_busy, s_done, slv_done, s_mm_write, s_mm_waitrequest;
    logic [31:0] s_returndata, slv_returndata, s_mm_address, s_mm_writedata;
    logic [31:0] got[$];
    int          n_fail = 0, num_checks = 0;
    always #50 clk = ~clk;
    invocation_control #(.INIT_CYCLES(3)) u_invocation_control (
        .clk(clk), .rst_n(rst_n), .start(start), .busy(busy), .stall(stall), .done(done),
        .returndata(returndata), .arg_in(arg_in), .stable_arg(stable_arg), .slv_start_wr(1'b0),
        .slv_done_clr(1'b0), .slv_done(), .slv_returndata(), .ptr_addr(ptr_addr),
        .glob_addr(glob_addr), .mm_address(mm_address), .mm_write(mm_write),
        .mm_writedata(mm_writedata), .mm_waitrequest(mm_waitrequest));
    mem_model u_mem_model (.clk(clk), .rst_n(rst_n), .slow(slow), .mm_address(mm_address),
        .mm_write(mm_write), .mm_writedata(mm_writedata), .mm_waitrequest(mm_waitrequest));
    // Slave-register variant: start pin unused, request and completion in registers
    invocation_control #(.MODE(inv_ctrl_pkg::MODE_SLAVE_REG), .INIT_CYCLES(3)) u_invocation_control_slv (
        .clk(clk), .rst_n(rst_n), .start(1'b0), .busy(s_busy), .stall(1'b0), .done(s_done),
        .returndata(s_returndata), .arg_in(arg_in), .stable_arg(stable_arg), .slv_start_wr(slv_start_wr),
        .slv_done_clr(slv_done_clr), .slv_done(slv_done), .slv_returndata(slv_returndata),
        .ptr_addr(ptr_addr), .glob_addr(glob_addr), .mm_address(s_mm_address), .mm_write(s_mm_write),
        .mm_writedata(s_mm_writedata), .mm_waitrequest(s_mm_waitrequest));
    mem_model u_mem_slv (.clk(clk), .rst_n(rst_n), .slow(slow), .mm_address(s_mm_address),
        .mm_write(s_mm_write), .mm_writedata(s_mm_writedata), .mm_waitrequest(s_mm_waitrequest));
    // Collect results taken downstream
    always @(negedge clk) if (rst_n && done === 1'b1 && stall === 1'b0) got.push_back(returndata);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic clear;
        got.delete();
        u_mem_model.wa.delete();
        u_mem_model.wd.delete();
    endtask : clear
    // Hold start until taken; returns at the accepting edge
    task automatic invoke(input logic [31:0] a);
        int n = 0;
        bit ok;
        start <= 1'b1;
        arg_in <= a;
        do begin
            @(negedge clk);
            ok = (busy === 1'b0);
            @(posedge clk);
            n++;
        end while (!ok && n < 200);
        chk(32'(ok), 32'h1);
    endtask : invoke
    task automatic t_reset;
        int n = 0;
        @(posedge clk);
        rst_n <= 1'b0;
        start <= 1'b0;
        repeat (20) @(posedge clk);
        #1 chk(busy, 1);
        chk(done, 0);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk(busy, 1);
        while (busy !== 1'b0 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        chk(busy, 0);
        chk(32'(n), 32'h2);
        clear();
    endtask : t_reset
    task automatic t_single;
        clear();
        @(posedge clk);
        invoke(32'h0000_0011);
        start <= 1'b0;
        repeat (30) @(posedge clk);
        chk(32'(got.size()), 1);
        chk(got[0], 32'h0000_0011 + stable_arg);
        chk(u_mem_model.wa[0], ptr_addr);
        chk(u_mem_model.wa[1], glob_addr);
        chk(u_mem_model.wd[1], 32'h0000_0011 + stable_arg);
    endtask : t_single
    // Slave variant: pulse start register, wait for done flag, clear it
    task automatic t_slave;
        int n = 0;
        @(posedge clk);
        arg_in       <= 32'h0000_0033;
        slv_start_wr <= 1'b1;
        @(posedge clk);
        slv_start_wr <= 1'b0;
        while (slv_done !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        chk(slv_done, 1);
        chk(slv_returndata, 32'h0000_0033 + stable_arg);
        chk(s_done, 0);
        chk(32'(u_mem_slv.wa.size()), 2);
        @(posedge clk);
        slv_done_clr <= 1'b1;
        @(posedge clk);
        slv_done_clr <= 1'b0;
        @(negedge clk);
        chk(slv_done, 0);
    endtask : t_slave
    task automatic t_burst;
        clear();
        @(posedge clk);
        stall <= 1'b1;
        slow <= 1'b1;
        fork begin repeat (30) @(posedge clk); stall <= 1'b0; end join_none
        for (int i = 0; i < 6; i++) invoke(32'h0000_0020 + i);
        start <= 1'b0;
        repeat (80) @(posedge clk);
        slow <= 1'b0;
        chk(32'(got.size()), 6);
        for (int i = 0; i < 6; i++) chk(got[i], 32'h0000_0020 + i + stable_arg);
        chk(32'(u_mem_model.wa.size()), 12);
    endtask : t_burst
    task automatic t_midreset;
        int n = 0;
        @(posedge clk);
        invoke(32'h0000_0055);
        start <= 1'b0;
        // Cut the invocation while its stores are under way
        while (mm_write !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        chk(mm_write, 1);
        t_reset();
        repeat (30) @(posedge clk);
        chk(32'(got.size()), 0);
        chk(32'(u_mem_model.wa.size()), 0);
    endtask : t_midreset
    // Stop a hung run
    initial begin
        #3000000;
        n_fail++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        t_reset();
        t_single();
        t_slave();
        t_burst();
        t_midreset();
        t_single();
        tally_and_finish();
    end
endmodule : tb
